//--- rtl/bfe_engine.sv
// bfe_engine: 2D block transfer and fill engine, Wishbone register slave
// assumes: one flat memory port covering system and frame buffer memory
//
// Summary of operation
// - memory moves use one 128-bit data word
// - destination equals source except raster op, transparency
// - any memory region to any memory region
// - source is memory, pattern or solid fill
// - pattern is 8x8 tile, 8/16/32 bpp
// - monochrome source expands to 8/16/32 bpp
// - opaque mode writes every computed pixel
// - transparent mode writes by source/destination compare
// - all 256 raster ops, transparent too
// - output aligned to destination rectangle
// - command picks start corner for overlaps
// - engine fetches command batches from memory
// - writes outside the clip rectangle are suppressed
`timescale 1ns/1ns
module bfe_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_adr_o,
  output logic [127:0] mem_wdat_o,
  output logic [15:0] mem_be_o,
  input wire logic mem_ack_i,
  input wire logic [127:0] mem_rdat_i,
  output logic busy_o
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_SETUP, ST_SETTLE, ST_SRC, ST_PAT,
    ST_DST, ST_WRITE, ST_STEP, ST_NEXT, ST_FIN
  } bfe_state_e;

  bfe_state_e state_r;
  bfe_state_e state_nxt;
  logic ack_r;
  logic [31:0] dat_r;
  logic wb_req;
  logic wb_wr;
  logic start;
  logic done_r;
  logic [31:0] cmd_base_r;
  logic [31:0] cmd_count_r;
  logic [31:0] clip_min_r;
  logic [31:0] clip_max_r;
  logic [31:0] bg_r;
  logic [31:0] done_cnt_r;
  logic [31:0] remain_r;
  logic [31:0] cmd_ptr_r;
  logic [1:0] k_r;
  logic [127:0] cw_r [3];
  logic gap_r;
  logic mack;
  logic [31:0] src_r;
  logic [31:0] pat_r;
  logic [31:0] dst_r;
  logic [31:0] adr_r;
  logic we_r;
  logic [127:0] wdat_r;
  logic [15:0] be_r;

  // ==========================================================
  // command fields
  logic [7:0] rop;
  logic [1:0] src_sel;
  logic [1:0] bpp;
  logic [1:0] sh;
  logic mono;
  logic trans;
  logic tmode;
  logic stretch;
  logic [15:0] dw;
  logic [15:0] dh;
  logic [31:0] fill;
  logic [31:0] saddr;
  logic [31:0] daddr;
  logic [15:0] spitch;
  logic [15:0] dpitch;
  logic [31:0] paddr;
  logic [15:0] dx0;
  logic [15:0] dy0;

  assign rop = cw_r[0][bfe_pkg::F_ROP +: 8];
  assign src_sel = cw_r[0][bfe_pkg::F_SRC +: 2];
  assign bpp = cw_r[0][bfe_pkg::F_BPP +: 2];
  assign sh = (bpp == 2'h3) ? 2'h2 : bpp;
  assign mono = cw_r[0][bfe_pkg::F_MONO];
  assign trans = cw_r[0][bfe_pkg::F_TRANS];
  assign tmode = cw_r[0][bfe_pkg::F_TMODE];
  assign stretch = cw_r[0][bfe_pkg::F_STRETCH];
  assign dw = cw_r[0][bfe_pkg::F_DW +: 16];
  assign dh = cw_r[0][bfe_pkg::F_DH +: 16];
  assign fill = cw_r[0][bfe_pkg::F_FILL +: 32];
  assign saddr = cw_r[1][bfe_pkg::F_SADDR +: 32];
  assign daddr = cw_r[1][bfe_pkg::F_DADDR +: 32];
  assign spitch = cw_r[1][bfe_pkg::F_SPITCH +: 16];
  assign dpitch = cw_r[1][bfe_pkg::F_DPITCH +: 16];
  assign paddr = cw_r[1][bfe_pkg::F_PADDR +: 32];
  assign dx0 = cw_r[2][bfe_pkg::F_DX +: 16];
  assign dy0 = cw_r[2][bfe_pkg::F_DY +: 16];

  // ==========================================================
  // traversal axes
  bfe_axis_if ax_x();
  bfe_axis_if ax_y();

  bfe_axis u_axis_x (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ax(ax_x)
  );

  bfe_axis u_axis_y (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ax(ax_y)
  );

  assign ax_x.len = dw;
  assign ax_y.len = dh;
  assign ax_x.slen = stretch ? cw_r[0][bfe_pkg::F_SW +: 16] : dw;
  assign ax_y.slen = stretch ? cw_r[0][bfe_pkg::F_SH +: 16] : dh;
  assign ax_x.rev = cw_r[0][bfe_pkg::F_XREV];
  assign ax_y.rev = cw_r[0][bfe_pkg::F_YREV];
  assign ax_x.init = (state_r == ST_SETUP)
                   || (state_r == ST_STEP && ax_x.last && !ax_y.last);
  assign ax_x.adv = (state_r == ST_STEP) && !ax_x.last;
  assign ax_y.init = (state_r == ST_SETUP);
  assign ax_y.adv = (state_r == ST_STEP) && ax_x.last && !ax_y.last;

  // ==========================================================
  // pixel addressing and operands
  logic [31:0] pmask;
  logic [3:0] pbe;
  logic [15:0] dcx;
  logic [15:0] dcy;
  logic [31:0] src_a;
  logic [31:0] pat_a;
  logic [31:0] dst_a;
  logic [31:0] s_op;
  logic [31:0] res;
  logic clipped;
  logic wr_en;
  logic [31:0] src_w;

  function automatic logic [31:0] bfe_pick(input logic [127:0] w,
                                           input logic [3:0] off);
    logic [127:0] t;
    t = w >> {off, 3'b000};
    return t[31:0];
  endfunction

  function automatic logic [31:0] bfe_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    unique case (sh)
      2'h0:
      begin
        pmask = 32'h0000_00FF;
        pbe = 4'h1;
      end
      2'h1:
      begin
        pmask = 32'h0000_FFFF;
        pbe = 4'h3;
      end
      default:
      begin
        pmask = 32'hFFFF_FFFF;
        pbe = 4'hF;
      end
    endcase
  end

  // destination follows the rectangle, not the source alignment
  assign dcx = dx0 + ax_x.pos;
  assign dcy = dy0 + ax_y.pos;
  assign src_a = saddr + {16'h0000, ax_y.spos} * {16'h0000, spitch}
               + (mono ? {19'h00000, ax_x.spos[15:3]}
                       : {16'h0000, ax_x.spos} << sh);
  assign pat_a = paddr + ({26'h0000000, ax_y.pos[2:0], ax_x.pos[2:0]}
                          << sh);
  assign dst_a = daddr + {16'h0000, dcy} * {16'h0000, dpitch}
               + ({16'h0000, dcx} << sh);
  assign clipped = dcx < clip_min_r[15:0] || dcx > clip_max_r[15:0]
                || dcy < clip_min_r[31:16]
                || dcy > clip_max_r[31:16];
  assign src_w = bfe_pick(mem_rdat_i, src_a[3:0]);

  always_comb
  begin
    unique case (src_sel)
      bfe_pkg::BFE_SRC_PAT: s_op = pat_r;
      bfe_pkg::BFE_SRC_SOLID: s_op = fill & pmask;
      default: s_op = src_r;
    endcase
  end

  bfe_rop u_rop (
    .rop_i(rop),
    .src_i(s_op),
    .pat_i(pat_r),
    .dst_i(dst_r),
    .res_o(res)
  );

  // opaque writes always, transparent by colour compare
  assign wr_en = !trans || (tmode ? (s_op == dst_r)
                                  : (s_op != dst_r));

  // ==========================================================
  // sequencer
  assign mack = mem_ack_i && mem_req_o;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (start)
          state_nxt = (cmd_count_r == 32'h0) ? ST_FIN : ST_FETCH;
      ST_FETCH:
        if (mack && k_r == bfe_pkg::CMD_LAST_WORD)
          state_nxt = ST_SETUP;
      ST_SETUP:
        state_nxt = (dw == 16'h0 || dh == 16'h0) ? ST_NEXT : ST_SETTLE;
      ST_SETTLE:
        if (ax_x.ready && ax_y.ready)
        begin
          if (clipped)
            state_nxt = ST_STEP;
          else if (src_sel == bfe_pkg::BFE_SRC_MEM)
            state_nxt = ST_SRC;
          else
            state_nxt = ST_PAT;
        end
      ST_SRC:
        if (mack)
          state_nxt = ST_PAT;
      ST_PAT:
        if (mack)
          state_nxt = ST_DST;
      ST_DST:
        if (mack)
          state_nxt = ST_WRITE;
      ST_WRITE:
        if (mack || !wr_en)
          state_nxt = ST_STEP;
      ST_STEP:
        state_nxt = (ax_x.last && ax_y.last) ? ST_NEXT : ST_SETTLE;
      ST_NEXT:
        state_nxt = (remain_r == 32'h1) ? ST_FIN : ST_FETCH;
      ST_FIN:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // batch bookkeeping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remain_r <= bfe_pkg::RST_ZERO;
      cmd_ptr_r <= bfe_pkg::RST_ZERO;
      k_r <= 2'h0;
      done_cnt_r <= bfe_pkg::RST_ZERO;
    end
    else if (start)
    begin
      remain_r <= cmd_count_r;
      cmd_ptr_r <= cmd_base_r;
      k_r <= 2'h0;
      done_cnt_r <= bfe_pkg::RST_ZERO;
    end
    else if (state_r == ST_FETCH && mack)
    begin
      k_r <= k_r + 2'h1;
      cmd_ptr_r <= cmd_ptr_r + bfe_pkg::CMD_WORD_BYTES;
    end
    else if (state_r == ST_NEXT)
    begin
      k_r <= 2'h0;
      remain_r <= remain_r - 32'h1;
      done_cnt_r <= done_cnt_r + 32'h1;
    end
  end

  // command words and pixel operands captured on memory answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 3; i++)
        cw_r[i] <= 128'h0;
      src_r <= bfe_pkg::RST_ZERO;
      pat_r <= bfe_pkg::RST_ZERO;
      dst_r <= bfe_pkg::RST_ZERO;
    end
    else if (mack)
    begin
      if (state_r == ST_FETCH)
        cw_r[k_r] <= mem_rdat_i;
      if (state_r == ST_SRC && mono)
        src_r <= src_w[3'h7 - ax_x.spos[2:0]] ? fill & pmask
                                               : bg_r & pmask;
      else if (state_r == ST_SRC)
        src_r <= src_w & pmask;
      if (state_r == ST_PAT)
        pat_r <= bfe_pick(mem_rdat_i, pat_a[3:0]) & pmask;
      if (state_r == ST_DST)
        dst_r <= bfe_pick(mem_rdat_i, dst_a[3:0]) & pmask;
    end
  end

  // ==========================================================
  // memory port: one 128-bit word per access, idle cycle between
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gap_r <= 1'b1;
    else
      gap_r <= (state_nxt != state_r) || mack;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adr_r <= bfe_pkg::RST_ZERO;
      we_r <= 1'b0;
      wdat_r <= 128'h0;
      be_r <= 16'h0000;
    end
    else
    begin
      we_r <= (state_r == ST_WRITE);
      be_r <= 16'hFFFF;
      wdat_r <= 128'h0;
      unique case (state_r)
        ST_FETCH: adr_r <= cmd_ptr_r;
        ST_SRC: adr_r <= src_a;
        ST_PAT: adr_r <= pat_a;
        ST_DST: adr_r <= dst_a;
        ST_WRITE:
        begin
          adr_r <= dst_a;
          wdat_r <= {96'h0, res & pmask} << {dst_a[3:0], 3'b000};
          be_r <= {12'h000, pbe} << dst_a[3:0];
        end
        default: adr_r <= adr_r;
      endcase
    end
  end

  always_comb
  begin
    unique case (state_r)
      ST_FETCH, ST_SRC, ST_PAT, ST_DST:
        mem_req_o = !gap_r;
      ST_WRITE:
        mem_req_o = !gap_r && wr_en;
      default:
        mem_req_o = 1'b0;
    endcase
  end

  assign mem_we_o = we_r;
  assign mem_adr_o = {adr_r[31:4], 4'h0};
  assign mem_wdat_o = wdat_r;
  assign mem_be_o = be_r;
  assign busy_o = (state_r != ST_IDLE);

  // ==========================================================
  // Wishbone register slave
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && !ack_r;
  assign start = wb_wr && wb_adr_i == bfe_pkg::REG_CTRL && wb_sel_i[0]
              && wb_dat_i[bfe_pkg::CTRL_START] && state_r == ST_IDLE;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req && !ack_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= bfe_pkg::RST_ZERO;
    else if (wb_req && !ack_r && !wb_we_i)
    begin
      unique case (wb_adr_i)
        bfe_pkg::REG_STATUS: dat_r <= {30'h0, done_r, busy_o};
        bfe_pkg::REG_CMD_BASE: dat_r <= cmd_base_r;
        bfe_pkg::REG_CMD_COUNT: dat_r <= cmd_count_r;
        bfe_pkg::REG_CLIP_MIN: dat_r <= clip_min_r;
        bfe_pkg::REG_CLIP_MAX: dat_r <= clip_max_r;
        bfe_pkg::REG_BG: dat_r <= bg_r;
        bfe_pkg::REG_DONE_CNT: dat_r <= done_cnt_r;
        default: dat_r <= bfe_pkg::RST_ZERO;
      endcase
    end
  end

  // setup registers are frozen while a batch runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_base_r <= bfe_pkg::RST_ZERO;
      cmd_count_r <= bfe_pkg::RST_ZERO;
      clip_min_r <= bfe_pkg::RST_ZERO;
      clip_max_r <= bfe_pkg::RST_CLIP_MAX;
      bg_r <= bfe_pkg::RST_ZERO;
    end
    else if (wb_wr && !busy_o)
    begin
      unique case (wb_adr_i)
        bfe_pkg::REG_CMD_BASE:
          cmd_base_r <= bfe_merge(cmd_base_r, wb_dat_i, wb_sel_i);
        bfe_pkg::REG_CMD_COUNT:
          cmd_count_r <= bfe_merge(cmd_count_r, wb_dat_i, wb_sel_i);
        bfe_pkg::REG_CLIP_MIN:
          clip_min_r <= bfe_merge(clip_min_r, wb_dat_i, wb_sel_i);
        bfe_pkg::REG_CLIP_MAX:
          clip_max_r <= bfe_merge(clip_max_r, wb_dat_i, wb_sel_i);
        bfe_pkg::REG_BG:
          bg_r <= bfe_merge(bg_r, wb_dat_i, wb_sel_i);
        default: bg_r <= bg_r;
      endcase
    end
  end

  // done is sticky, write one to clear, finishing batch wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_r <= 1'b0;
    else if (state_r == ST_FIN)
      done_r <= 1'b1;
    else if (wb_wr && wb_adr_i == bfe_pkg::REG_STATUS && wb_sel_i[0]
             && wb_dat_i[bfe_pkg::STAT_DONE])
      done_r <= 1'b0;
  end
endmodule

//--- rtl/bfe_pkg.sv
// bfe_pkg: constants and types of the 2D block transfer and fill engine
// assumes: compiled before every other engine file
package bfe_pkg;
  // ==========================================================
  // datapath
  localparam int DATA_W = 128;
  localparam int BE_W = 16;
  localparam int CW = 16;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CMD_BASE = 8'h08;
  localparam logic [7:0] REG_CMD_COUNT = 8'h0C;
  localparam logic [7:0] REG_CLIP_MIN = 8'h10;
  localparam logic [7:0] REG_CLIP_MAX = 8'h14;
  localparam logic [7:0] REG_BG = 8'h18;
  localparam logic [7:0] REG_DONE_CNT = 8'h1C;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CLIP_MAX = 32'hFFFF_FFFF;

  // ==========================================================
  // command buffer layout: three 128-bit words per command
  localparam logic [1:0] CMD_LAST_WORD = 2'h2;
  localparam logic [31:0] CMD_WORD_BYTES = 32'h0000_0010;
  localparam int F_ROP = 0;
  localparam int F_SRC = 8;
  localparam int F_BPP = 10;
  localparam int F_MONO = 12;
  localparam int F_TRANS = 13;
  localparam int F_TMODE = 14;
  localparam int F_STRETCH = 15;
  localparam int F_XREV = 16;
  localparam int F_YREV = 17;
  localparam int F_DW = 32;
  localparam int F_DH = 48;
  localparam int F_SW = 64;
  localparam int F_SH = 80;
  localparam int F_FILL = 96;
  localparam int F_SADDR = 0;
  localparam int F_DADDR = 32;
  localparam int F_SPITCH = 64;
  localparam int F_DPITCH = 80;
  localparam int F_PADDR = 96;
  localparam int F_DX = 0;
  localparam int F_DY = 16;

  typedef enum logic [1:0] {
    BFE_SRC_MEM,
    BFE_SRC_PAT,
    BFE_SRC_SOLID
  } bfe_src_e;
endpackage

//--- rtl/bfe_axis_if.sv
// bfe_axis_if: control and position of one traversal axis
// assumes: driven by the engine, answered by one bfe_axis
`timescale 1ns/1ns
interface bfe_axis_if;
  logic init;
  logic adv;
  logic rev;
  logic [15:0] len;
  logic [15:0] slen;
  logic [15:0] pos;
  logic [15:0] spos;
  logic last;
  logic ready;
  modport ctl(output init, adv, rev, len, slen,
              input pos, spos, last, ready);
  modport axis(input init, adv, rev, len, slen,
               output pos, spos, last, ready);
endinterface

//--- rtl/bfe_axis.sv
// bfe_axis: destination counter and nearest source index of one axis
// assumes: len and slen held stable from init to the last step
`timescale 1ns/1ns
module bfe_axis (
  input wire logic clk_i,
  input wire logic rst_i,
  bfe_axis_if.axis ax
);
  logic [15:0] i_r;
  logic [15:0] si_r;
  logic [16:0] acc_r;
  logic settle;

  // source index walks until acc falls below len: replication or decimation
  assign settle = (acc_r >= {1'b0, ax.len}) && (ax.len != 16'h0000);
  assign ax.ready = !settle;
  assign ax.last = (i_r == ax.len - 16'h0001);
  assign ax.pos = ax.rev ? ax.len - 16'h0001 - i_r : i_r;
  assign ax.spos = ax.rev ? ax.slen - 16'h0001 - si_r : si_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      i_r <= 16'h0000;
      si_r <= 16'h0000;
      acc_r <= 17'h00000;
    end
    else if (ax.init)
    begin
      i_r <= 16'h0000;
      si_r <= 16'h0000;
      acc_r <= {2'b00, ax.slen[15:1]};
    end
    else if (settle)
    begin
      si_r <= si_r + 16'h0001;
      acc_r <= acc_r - {1'b0, ax.len};
    end
    else if (ax.adv)
    begin
      i_r <= i_r + 16'h0001;
      acc_r <= acc_r + {1'b0, ax.slen};
    end
  end
endmodule

//--- rtl/bfe_rop.sv
// bfe_rop: three-operand raster operation over one 32-bit pixel
// assumes: operands already masked to the pixel depth
`timescale 1ns/1ns
module bfe_rop (
  input wire logic [7:0] rop_i,
  input wire logic [31:0] src_i,
  input wire logic [31:0] pat_i,
  input wire logic [31:0] dst_i,
  output logic [31:0] res_o
);
  // code is a truth table indexed by pattern, source, destination
  for (genvar b = 0; b < 32; b++)
  begin : g_bit
    assign res_o[b] = rop_i[{pat_i[b], src_i[b], dst_i[b]}];
  end
endmodule

//--- testbench/bfe_mem_model.sv
// bfe_mem_model: flat 4 KiB memory behind the engine's memory port
// assumes: word index adr_i[11:4], dly_i wait cycles before each ack
`timescale 1ns/1ns
module bfe_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [127:0] wdat_i,
  input wire logic [15:0] be_i,
  input wire logic [2:0] dly_i,
  output logic ack_o,
  output logic [127:0] rdat_o
);
  logic [127:0] mem [0:255];
  logic [2:0] wait_r = 3'h0;

  initial
  begin
    ack_o = 1'b0;
    rdat_o = '0;
    foreach (mem[i])
      mem[i] = '0;
  end

  // ==========================================================
  // one access per request, ack for one cycle
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdat_o <= ~rdat_o; // read data not held past the ack
    if (req_i && !ack_o && wait_r < dly_i)
      wait_r <= wait_r + 3'h1;
    else if (req_i && !ack_o)
    begin
      wait_r <= 3'h0;
      ack_o <= 1'b1;
      rdat_o <= mem[adr_i[11:4]];
      for (int b = 0; b < 16; b++)
        if (we_i && be_i[b])
          mem[adr_i[11:4]][b*8 +: 8] <= wdat_i[b*8 +: 8];
    end
  end
endmodule

//--- testbench/bfe_engine_checker.sv
// bfe_engine_checker: port assertions of the block transfer engine
// assumes: bound to bfe_engine, one clock domain
`timescale 1ns/1ns
module bfe_engine_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_adr_o,
  input wire logic [127:0] mem_wdat_o,
  input wire logic [15:0] mem_be_o,
  input wire logic mem_ack_i,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // sequences
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_start;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !busy_o &&
      wb_adr_i == bfe_pkg::REG_CTRL && wb_sel_i[0] && wb_dat_i[0];
  endsequence
  sequence s_mem_wait;
    mem_req_o && !mem_ack_i;
  endsequence

  // ==========================================================
  // assertions
  AST_WB_ACK: assert property (s_wb_req |=> wb_ack_o)
    else $error("register request not acked next cycle");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_START: assert property (s_start |=> busy_o)
    else $error("start did not make the engine busy");
  AST_FETCH: assert property ($rose(busy_o) |-> ##[1:4] mem_req_o)
    else $error("no command fetch after start");
  AST_MEM_HOLD: assert property (s_mem_wait |=> mem_req_o &&
    $stable(mem_adr_o) && $stable(mem_we_o) && $stable(mem_wdat_o) &&
    $stable(mem_be_o))
    else $error("memory request changed before ack");
  AST_MEM_GAP: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("memory request not dropped after ack");
  AST_ALIGN: assert property (mem_req_o |-> mem_adr_o[3:0] == 4'h0)
    else $error("memory address not word aligned");
  AST_RD_BE: assert property (mem_req_o && !mem_we_o |->
    mem_be_o == 16'hFFFF)
    else $error("read without full byte enables");
  AST_WR_BE: assert property (mem_req_o && mem_we_o |->
    $countones(mem_be_o) inside {1, 2, 4})
    else $error("write byte enables not one pixel");
  AST_IDLE: assert property (!busy_o |-> !mem_req_o)
    else $error("memory request while idle");
endmodule

bind bfe_engine bfe_engine_checker i_bfe_engine_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o), .mem_wdat_o(mem_wdat_o),
  .mem_be_o(mem_be_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o));

//--- testbench/tb_top.sv
// tb_top: self-checking bench of the block transfer engine
// assumes: bfe_mem_model serves commands, pattern, source, destination
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, req, mwe, mack, busy;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, wbrd, rd, madr;
  logic [127:0] wdat, rdat;
  logic [15:0] be;
  logic [2:0] dly = 3'h0;
  int fail_count = 0, n_checks = 0, cyc_n = 0;
  localparam logic [127:0] W1 = {32'h0000_0100, 16'h0010, 16'h0010,
    32'h0000_0400, 32'h0000_0200};

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  bfe_engine i_bfe_engine (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(wbrd), .wb_ack_o(ack), .mem_req_o(req),
    .mem_we_o(mwe), .mem_adr_o(madr), .mem_wdat_o(wdat), .mem_be_o(be),
    .mem_ack_i(mack), .mem_rdat_i(rdat), .busy_o(busy));
  bfe_mem_model i_bfe_mem_model (.clk_i(clk_i), .req_i(req), .we_i(mwe),
    .adr_i(madr), .wdat_i(wdat), .be_i(be), .dly_i(dly), .ack_o(mack),
    .rdat_o(rdat));

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = wbrd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 100)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    check(nm, e, rd);
  endtask

  task automatic put(input logic [7:0] w, input logic [127:0] v);
    i_bfe_mem_model.mem[w] = v;
  endtask

  function automatic logic [31:0] get(input logic [7:0] w);
    return i_bfe_mem_model.mem[w][31:0];
  endfunction

  function automatic logic [127:0] cw(input logic [7:0] op,
    input logic [1:0] sr, input logic [1:0] bp, input logic [1:0] tt,
    input logic [15:0] dw, input logic [31:0] fc);
    return {fc, 32'h0, 16'h1, dw, 16'h0, 1'b0, tt, 1'b0, bp, sr, op};
  endfunction

  function automatic logic [31:0] rop_ref(input logic [7:0] op,
    input logic [31:0] p, input logic [31:0] s, input logic [31:0] d);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = op[{p[i], s[i], d[i]}];
    return r;
  endfunction

  task automatic run(input logic [127:0] w0, input logic [127:0] w1);
    int n;
    n = 0;
    put(8'h00, w0);
    put(8'h01, w1);
    put(8'h02, '0);
    wb(1'b1, bfe_pkg::REG_CMD_COUNT, 32'h1, 4'hF);
    wb(1'b1, bfe_pkg::REG_CTRL, 32'h1, 4'hF);
    @(posedge clk_i);
    check("busy", 32'h1, {31'h0, busy});
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    rchk("clip_max", bfe_pkg::REG_CLIP_MAX, 32'hFFFF_FFFF);
    rchk("clip_min", bfe_pkg::REG_CLIP_MIN, 32'h0);
    rchk("status", bfe_pkg::REG_STATUS, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    wb(1'b1, bfe_pkg::REG_BG, 32'hFFFF_FFFF, 4'h3);
    rchk("bg", bfe_pkg::REG_BG, 32'h0000_FFFF);
  endtask

  task automatic t_fill();
    put(8'h40, {16{8'h11}});
    wb(1'b1, bfe_pkg::REG_CLIP_MAX, 32'hFFFF_0002, 4'hF);
    run(cw(8'hCC, 2'h2, 2'h0, 2'h0, 16'h4, 32'hA5), W1);
    check("fill", 32'h11A5_A5A5, get(8'h40));
    rchk("done_cnt", bfe_pkg::REG_DONE_CNT, 32'h1);
    rchk("done", bfe_pkg::REG_STATUS, 32'h2);
    wb(1'b1, bfe_pkg::REG_STATUS, 32'h2, 4'hF);
    rchk("cleared", bfe_pkg::REG_STATUS, 32'h0);
    wb(1'b1, bfe_pkg::REG_CLIP_MAX, 32'hFFFF_FFFF, 4'hF);
  endtask

  task automatic t_rop();
    logic [7:0] ops [8] = '{8'hCC, 8'h66, 8'h88, 8'hEE, 8'h00, 8'hFF,
                            8'hF0, 8'h5A};
    dly <= 3'h2;
    put(8'h10, 128'hF0F0_3C3C);
    foreach (ops[k])
    begin
      put(8'h20, 128'h0F0F_00FF);
      put(8'h40, 128'h33CC_55AA);
      run(cw(ops[k], 2'h0, 2'h2, 2'h0, 16'h1, 32'h0), W1);
      check("rop", rop_ref(ops[k], 32'hF0F0_3C3C, 32'h0F0F_00FF,
        32'h33CC_55AA), get(8'h40));
    end
    dly <= 3'h0;
  endtask

  task automatic t_trans();
    for (int m = 0; m < 2; m++)
    begin
      put(8'h20, 128'h4422);
      put(8'h40, 128'h9922);
      run(cw(8'h33, 2'h0, 2'h0, {m[0], 1'b1}, 16'h2, 32'h0), W1);
      check("trans", m ? 32'h99DD : 32'hBB22, get(8'h40));
    end
  endtask

  task automatic t_rev();
    put(8'h40, 128'h4422);
    run(cw(8'hCC, 2'h0, 2'h0, 2'h0, 16'h2, 32'h0) | 128'h1_0000,
      {W1[127:64], 32'h0000_0401, 32'h0000_0400});
    check("overlap", 32'h0044_2222, get(8'h40));
  endtask

  task automatic t_mono();
    put(8'h20, 128'h80);
    put(8'h40, 128'h0);
    run(cw(8'hCC, 2'h0, 2'h0, 2'h0, 16'h4, 32'h5A)
      | 128'h0001_0002_0000_0000_0000_9000, W1);
    check("mono", 32'hFFFF_5A5A, get(8'h40));
    put(8'h10, 128'h0201);
    run(cw(8'hCC, 2'h1, 2'h0, 2'h0, 16'h2, 32'h0), W1);
    check("pattern", 32'hFFFF_0201, get(8'h40));
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fill();
    t_rop();
    t_trans();
    t_rev();
    t_mono();
    finish_test();
  end
endmodule
